/* File: rtl/ccr_cfg_regs.sv */
// configuration register bank of a single-cell charger behind an i2c slave
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - input limit code is 100mA plus 50mA/step, default 001000; pin limit caps it
// - finished source detection overwrites the input limit code
// - source select high loads 500mA, low loads 3.25A
// - offset code is 100mV/step, 0 to 3100mV, default 00110; top bits reserved
// - computed input voltage threshold is held between 3.9V and 15.3V
// - unloaded input at or below 6V adds offset once, above 6V twice
// - writing 1 starts a conversion; bit resets to 0 meaning idle
// - continuous conversion set makes the start bit ignore writes
// - watchdog restart bit restarts the timer, then clears itself
// - charge enable defaults to 1; writing 0 stops charging
// - minimum system voltage code is 3.0V plus 0.1V/step, default 101
// - pulse commands act only while pulse control enable is 1, default 0
// - fast charge current code is 64mA/step, default 0100000
// - zero fast charge code stops charging; codes above 1001111 store 1001111
// - charge voltage code is 3.84V plus 16mV/step, default 010111
// - charge voltage codes above 110000 store 110000
// - watchdog expiry restores defaults except input limit and offset codes
// - slave address 6BH; reads past index 14h return FFh
module ccr_cfg_regs
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // serial bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_b,
  // analog and system inputs
  input  wire logic        source_select,
  input  wire logic        detect_done,
  input  wire logic        vbus_above_6v,
  input  wire logic [13:0] vbus_noload_mv,
  input  wire logic [5:0]  limit_setting_pin,
  input  wire logic        watchdog_expired,
  input  wire logic        reg_reset,
  input  wire logic        adc_done,
  // input regulation
  output logic             high_impedance_enable,
  output logic [5:0]       input_current_limit,
  output logic [13:0]      input_voltage_threshold,
  // conversion and watchdog
  output logic             conversion_start,
  output logic             continuous_conversion,
  output logic             watchdog_restart,
  // charge control
  output logic             battery_load_enable,
  output logic             charge_enable,
  output logic [2:0]       minimum_system_voltage,
  output logic             pulse_up_command,
  output logic             pulse_down_command,
  output logic [6:0]       fast_charge_current,
  output logic [3:0]       precharge_current,
  output logic [3:0]       termination_current,
  output logic [5:0]       charge_voltage,
  output logic             precharge_threshold_select,
  output logic             recharge_offset_select
);
  localparam int SW = 26;

  logic        wr_pulse;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data;
  logic [SW-1:0] s1_reg, s2_reg;
  logic [5:0]  s3_reg;
  logic [7:0]  src_reg, vos_reg, adc_reg, pwr_reg;
  logic [7:0]  fast_charge_current_reg, pre_reg, charge_voltage_reg, pump_reg;
  logic [7:0]  src_next, vos_next, adc_next, pwr_next;
  logic [7:0]  fast_charge_current_next, pre_next, charge_voltage_next, pump_next;

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  ccr_i2c_slave u_slave (
    .clk      (clk),
    .rst_b    (rst_b),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_b (sda_oe_b),
    .wr_pulse (wr_pulse),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [SW-1:0] pin_vec = {limit_setting_pin, vbus_noload_mv, source_select,
                           detect_done, vbus_above_6v, watchdog_expired,
                           reg_reset, adc_done};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= 6'h00;
    end else begin
      s1_reg <= pin_vec;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg[5:0];
    end
  end
  wire [5:0]  rise     = s2_reg[5:0] & ~s3_reg;
  wire        done_ev  = rise[0];
  wire        rrst_ev  = rise[1];
  wire        wdog_ev  = rise[2];
  wire        vbus_hi  = s2_reg[3];
  wire        det_ev   = rise[4];
  wire        psel     = s2_reg[5];
  wire [13:0] vbase    = s2_reg[19:6];
  wire [5:0]  pin_lim  = s2_reg[25:20];

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire wr_src  = wr_pulse && (wr_addr == A_SRC);
  wire wr_vos  = wr_pulse && (wr_addr == A_VOS);
  wire wr_adc  = wr_pulse && (wr_addr == A_ADC);
  wire wr_pwr  = wr_pulse && (wr_addr == A_PWR);
  wire wr_fast_charge_current = wr_pulse && (wr_addr == A_FAST_CHARGE_CURRENT);
  wire wr_pre  = wr_pulse && (wr_addr == A_PRE);
  wire wr_charge_voltage = wr_pulse && (wr_addr == A_CHARGE_VOLTAGE);
  wire wr_pump = wr_pulse && (wr_addr == A_PUMP);
  wire dflt    = rrst_ev | wdog_ev;

  // ----------------------------------------
  // input source control
  // ----------------------------------------
  wire [5:0] det_code = psel ? IIN_PSEL_HI : IIN_PSEL_LO;
  wire [7:0] src_host = wr_src ? wr_data : src_reg;
  wire [1:0] src_top  = wdog_ev ? R_SRC[7:6] : src_host[7:6];
  wire [5:0] src_low  = det_ev ? det_code : src_host[5:0];
  assign src_next = rrst_ev ? R_SRC : {src_top, src_low};

  // offset survives the watchdog
  assign vos_next = rrst_ev ? R_VOS : wr_vos ? (wr_data & M_VOS) : vos_reg;

  // ----------------------------------------
  // conversion control
  // ----------------------------------------
  wire rate_now   = adc_reg[B_RATE];
  wire conv_write = wr_adc && !rate_now;
  wire conv_bit   = conv_write ? wr_data[B_CONV] :
                    done_ev    ? 1'b0 : adc_reg[B_CONV];
  wire rate_bit   = wr_adc ? wr_data[B_RATE] : rate_now;
  wire [7:0] adc_live = {conv_bit, rate_bit, 6'h00} & M_ADC;
  assign adc_next = dflt ? R_ADC : adc_live;

  // ----------------------------------------
  // power control
  // ----------------------------------------
  wire [7:0] pwr_host = wr_pwr ? (wr_data & M_PWR) : pwr_reg;
  wire       wdr_set  = wr_pwr && wr_data[B_WDR];
  wire [7:0] pwr_live = {pwr_host[7], wdr_set, pwr_host[5:0]};
  assign pwr_next = dflt ? R_PWR : pwr_live;

  // ----------------------------------------
  // charge current and voltage
  // ----------------------------------------
  wire [6:0] fast_charge_current_in  = (wr_data[6:0] > FAST_CHARGE_CURRENT_MAX) ? FAST_CHARGE_CURRENT_MAX : wr_data[6:0];
  wire [7:0] fast_charge_current_wr  = {wr_data[B_PEN], fast_charge_current_in};
  assign fast_charge_current_next = dflt ? R_FAST_CHARGE_CURRENT : wr_fast_charge_current ? fast_charge_current_wr : fast_charge_current_reg;

  assign pre_next = dflt ? R_PRE : wr_pre ? wr_data : pre_reg;

  wire [5:0] charge_voltage_in  = (wr_data[7:2] > CHARGE_VOLTAGE_MAX) ? CHARGE_VOLTAGE_MAX : wr_data[7:2];
  wire [7:0] charge_voltage_wr  = {charge_voltage_in, wr_data[1:0]};
  assign charge_voltage_next = dflt ? R_CHARGE_VOLTAGE : wr_charge_voltage ? charge_voltage_wr : charge_voltage_reg;

  assign pump_next = dflt ? R_PUMP : wr_pump ? (wr_data & M_PUMP) : pump_reg;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_reg  <= R_SRC;
      vos_reg  <= R_VOS;
      adc_reg  <= R_ADC;
      pwr_reg  <= R_PWR;
      fast_charge_current_reg <= R_FAST_CHARGE_CURRENT;
      pre_reg  <= R_PRE;
      charge_voltage_reg <= R_CHARGE_VOLTAGE;
      pump_reg <= R_PUMP;
    end else begin
      src_reg  <= src_next;
      vos_reg  <= vos_next;
      adc_reg  <= adc_next;
      pwr_reg  <= pwr_next;
      fast_charge_current_reg <= fast_charge_current_next;
      pre_reg  <= pre_next;
      charge_voltage_reg <= charge_voltage_next;
      pump_reg <= pump_next;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  assign rd_data = (rd_addr == A_SRC)  ? src_reg  :
                   (rd_addr == A_VOS)  ? vos_reg  :
                   (rd_addr == A_ADC)  ? adc_reg  :
                   (rd_addr == A_PWR)  ? pwr_reg  :
                   (rd_addr == A_FAST_CHARGE_CURRENT) ? fast_charge_current_reg :
                   (rd_addr == A_PRE)  ? pre_reg  :
                   (rd_addr == A_CHARGE_VOLTAGE) ? charge_voltage_reg :
                   (rd_addr == A_PUMP) ? pump_reg :
                   (rd_addr > LAST_IDX) ? RD_BEYOND : RD_UNUSED;

  // ----------------------------------------
  // derived control values
  // ----------------------------------------
  wire [5:0]  iin_code = src_reg[5:0];
  wire        pin_on   = src_reg[B_ILEN];
  wire [5:0]  iin_eff  = (pin_on && (pin_lim < iin_code)) ? pin_lim : iin_code;

  wire [15:0] os_mv    = 16'(vos_reg[4:0]) * VOS_STEP_MV;
  wire [15:0] os_eff   = vbus_hi ? {os_mv[14:0], 1'b0} : os_mv;
  wire [15:0] vth_sum  = {2'b00, vbase} + os_eff;
  wire [15:0] vth_clip = (vth_sum < VTH_MIN_MV) ? VTH_MIN_MV :
                         (vth_sum > VTH_MAX_MV) ? VTH_MAX_MV : vth_sum;

  wire        pump_on  = fast_charge_current_reg[B_PEN];
  wire        up_eff   = pump_on & pump_reg[B_UP];
  wire        dn_eff   = pump_on & pump_reg[B_DN];
  wire        chg_eff  = pwr_reg[B_CHG] && (fast_charge_current_reg[6:0] != FAST_CHARGE_CURRENT_OFF);

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_impedance_enable      <= 1'b0;
      input_current_limit        <= 6'h00;
      input_voltage_threshold    <= 14'h0000;
      conversion_start           <= 1'b0;
      continuous_conversion      <= 1'b0;
      watchdog_restart           <= 1'b0;
      battery_load_enable        <= 1'b0;
      charge_enable              <= 1'b0;
      minimum_system_voltage     <= 3'h0;
      pulse_up_command           <= 1'b0;
      pulse_down_command         <= 1'b0;
      fast_charge_current        <= 7'h00;
      precharge_current          <= 4'h0;
      termination_current        <= 4'h0;
      charge_voltage             <= 6'h00;
      precharge_threshold_select <= 1'b0;
      recharge_offset_select     <= 1'b0;
    end else begin
      high_impedance_enable      <= src_reg[B_HIZ];
      input_current_limit        <= iin_eff;
      input_voltage_threshold    <= vth_clip[13:0];
      conversion_start           <= adc_reg[B_CONV];
      continuous_conversion      <= adc_reg[B_RATE];
      watchdog_restart           <= pwr_reg[B_WDR];
      battery_load_enable        <= pwr_reg[B_BLD];
      charge_enable              <= chg_eff;
      minimum_system_voltage     <= pwr_reg[F_SYS +: 3];
      pulse_up_command           <= up_eff;
      pulse_down_command         <= dn_eff;
      fast_charge_current        <= fast_charge_current_reg[6:0];
      precharge_current          <= pre_reg[F_IPRE +: 4];
      termination_current        <= pre_reg[3:0];
      charge_voltage             <= charge_voltage_reg[F_CHARGE_VOLTAGE +: 6];
      precharge_threshold_select <= charge_voltage_reg[B_BLOW];
      recharge_offset_select     <= charge_voltage_reg[B_RECH];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ccr_i2c_slave.sv */
// byte-level i2c slave with register pointer and auto-increment
`timescale 1ns/10ps
`default_nettype none
module ccr_i2c_slave
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b,
  // register side
  output logic            wr_pulse,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  logic [1:0]  scl_s, sda_s;
  logic        scl_d, sda_d;
  ccr_i2c_st_t st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        ackph_reg, ackph_next, nack_reg, nack_next;
  logic [7:0]  sh_reg, sh_next, tx_reg, tx_next, ptr_reg, ptr_next;
  logic        oeb_reg, oeb_next, wr_next;
  logic [7:0]  waddr_next, wdata_next;

  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  wire scl      = scl_s[1];
  wire sda      = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------
  // protocol sequencing
  // ----------------------------------------
  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    ackph_next = ackph_reg;
    nack_next  = nack_reg;
    sh_next    = sh_reg;
    tx_next    = tx_reg;
    ptr_next   = ptr_reg;
    oeb_next   = oeb_reg;
    wr_next    = 1'b0;
    waddr_next = wr_addr;
    wdata_next = wr_data;
    if (start_c) begin
      st_next    = ST_DEV;
      cnt_next   = 4'h0;
      ackph_next = 1'b0;
      oeb_next   = 1'b1;
    end else if (stop_c) begin
      st_next    = ST_IDLE;
      ackph_next = 1'b0;
      oeb_next   = 1'b1;
    end else if (st_reg != ST_IDLE) begin
      if (scl_rise) begin
        if (ackph_reg) begin
          nack_next = sda;
        end else if (cnt_reg < 4'h8) begin
          sh_next  = {sh_reg[6:0], sda};
          cnt_next = cnt_reg + 4'h1;
        end
      end else if (scl_fall) begin
        if (ackph_reg) begin
          ackph_next = 1'b0;
          cnt_next   = 4'h0;
          oeb_next   = 1'b1;
          if (st_reg == ST_RDATA) begin
            if (nack_reg) begin
              st_next = ST_IDLE;
            end else begin
              tx_next  = rd_data;
              oeb_next = rd_data[7];
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end else if (cnt_reg == 4'h8) begin
          ackph_next = 1'b1;
          nack_next  = 1'b0;
          unique case (st_reg)
            ST_DEV: begin
              if (sh_reg[7:1] == DEV_ADDR) begin
                oeb_next = 1'b0;
                st_next  = sh_reg[0] ? ST_RDATA : ST_REG;
              end else begin
                st_next    = ST_IDLE;
                ackph_next = 1'b0;
              end
            end
            ST_REG: begin
              if (sh_reg <= LAST_IDX) begin
                oeb_next = 1'b0;
                ptr_next = sh_reg;
                st_next  = ST_WDATA;
              end else begin
                st_next    = ST_IDLE;
                ackph_next = 1'b0;
              end
            end
            ST_WDATA: begin
              oeb_next   = 1'b0;
              wr_next    = 1'b1;
              waddr_next = ptr_reg;
              wdata_next = sh_reg;
              ptr_next   = ptr_reg + 8'h01;
            end
            ST_RDATA: oeb_next = 1'b1;
            ST_IDLE:  oeb_next = 1'b1;
          endcase
        end else if (st_reg == ST_RDATA) begin
          tx_next  = {tx_reg[6:0], 1'b0};
          oeb_next = tx_reg[6];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg    <= ST_IDLE;
      cnt_reg   <= 4'h0;
      ackph_reg <= 1'b0;
      nack_reg  <= 1'b0;
      sh_reg    <= 8'h00;
      tx_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      oeb_reg   <= 1'b1;
      wr_pulse  <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
      sda_out   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      ackph_reg <= ackph_next;
      nack_reg  <= nack_next;
      sh_reg    <= sh_next;
      tx_reg    <= tx_next;
      ptr_reg   <= ptr_next;
      oeb_reg   <= oeb_next;
      wr_pulse  <= wr_next;
      wr_addr   <= waddr_next;
      wr_data   <= wdata_next;
      sda_out   <= 1'b0;
    end
  end
  assign sda_oe_b = oeb_reg;
  assign rd_addr  = ptr_reg;
endmodule
`default_nettype wire

/* File: rtl/ccr_pkg.sv */
// shared constants and types for the charger configuration bank
package ccr_pkg;
  // ----------------------------------------
  // serial port
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR  = 7'h6b;
  localparam logic [7:0] LAST_IDX  = 8'h14;
  localparam logic [7:0] RD_BEYOND = 8'hff;
  localparam logic [7:0] RD_UNUSED = 8'h00;
  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] A_SRC  = 8'h00;
  localparam logic [7:0] A_VOS  = 8'h01;
  localparam logic [7:0] A_ADC  = 8'h02;
  localparam logic [7:0] A_PWR  = 8'h03;
  localparam logic [7:0] A_FAST_CHARGE_CURRENT = 8'h04;
  localparam logic [7:0] A_PRE  = 8'h05;
  localparam logic [7:0] A_CHARGE_VOLTAGE = 8'h06;
  localparam logic [7:0] A_PUMP = 8'h09;
  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] R_SRC  = 8'h48;
  localparam logic [7:0] R_VOS  = 8'h06;
  localparam logic [7:0] R_ADC  = 8'h00;
  localparam logic [7:0] R_PWR  = 8'h1a;
  localparam logic [7:0] R_FAST_CHARGE_CURRENT = 8'h20;
  localparam logic [7:0] R_PRE  = 8'h13;
  localparam logic [7:0] R_CHARGE_VOLTAGE = 8'h5e;
  localparam logic [7:0] R_PUMP = 8'h00;
  localparam logic [7:0] M_VOS  = 8'h1f;
  localparam logic [7:0] M_ADC  = 8'hc0;
  localparam logic [7:0] M_PWR  = 8'hde;
  localparam logic [7:0] M_PUMP = 8'h03;
  // ----------------------------------------
  // bit and field positions
  // ----------------------------------------
  localparam int B_HIZ  = 7;
  localparam int B_ILEN = 6;
  localparam int B_CONV = 7;
  localparam int B_RATE = 6;
  localparam int B_BLD  = 7;
  localparam int B_WDR  = 6;
  localparam int B_CHG  = 4;
  localparam int B_PEN  = 7;
  localparam int B_UP   = 1;
  localparam int B_DN   = 0;
  localparam int B_BLOW = 1;
  localparam int B_RECH = 0;
  localparam int F_SYS  = 1;
  localparam int F_CHARGE_VOLTAGE = 2;
  localparam int F_IPRE = 4;
  // ----------------------------------------
  // codes and millivolt figures
  // ----------------------------------------
  localparam logic [5:0]  IIN_PSEL_HI = 6'h08;
  localparam logic [5:0]  IIN_PSEL_LO = 6'h3f;
  localparam logic [6:0]  FAST_CHARGE_CURRENT_MAX    = 7'h4f;
  localparam logic [6:0]  FAST_CHARGE_CURRENT_OFF    = 7'h00;
  localparam logic [5:0]  CHARGE_VOLTAGE_MAX    = 6'h30;
  localparam logic [15:0] VOS_STEP_MV = 16'h0064;
  localparam logic [15:0] VTH_MIN_MV  = 16'h0f3c;
  localparam logic [15:0] VTH_MAX_MV  = 16'h3bc4;
  // ----------------------------------------
  // serial slave states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DEV   = 5'b00010,
    ST_REG   = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_RDATA = 5'b10000
  } ccr_i2c_st_t;
endpackage

/* File: verification/ccr_cfg_regs_bench.sv */
// self-checking bench for the charger configuration bank
`timescale 1ns/10ps
`default_nettype none
module ccr_cfg_regs_bench;
  import ccr_pkg::*;
  logic        clk, rst_b, scl, sda_low, sda_line, sda_out, sda_oe_b;
  logic        source_select, detect_done, vbus_above_6v, watchdog_expired, reg_reset, adc_done;
  logic [13:0] vbus_noload_mv, input_voltage_threshold;
  logic [5:0]  limit_setting_pin, input_current_limit, charge_voltage;
  logic [6:0]  fast_charge_current;
  logic        conversion_start, charge_enable, pulse_up_command, pulse_down_command;
  logic        high_impedance_enable, precharge_threshold_select;
  logic [2:0]  minimum_system_voltage;
  logic [8:0]  rx;
  int          mismatches, n_checks, cyc;
  logic [7:0]  idx [9] = '{A_SRC, A_VOS, A_ADC, A_PWR, A_FAST_CHARGE_CURRENT, A_PRE, A_CHARGE_VOLTAGE, A_PUMP, 8'h07};
  logic [7:0]  dflt [9] = '{R_SRC, R_VOS, R_ADC, R_PWR, R_FAST_CHARGE_CURRENT, R_PRE, R_CHARGE_VOLTAGE, R_PUMP, RD_UNUSED};
  // open-drain line with pull-up
  assign sda_line = !sda_low && (sda_oe_b || sda_out);
  ccr_host_model host_u (.clk, .sda_line, .scl, .sda_low);
  ccr_cfg_regs dut_u (
    .clk, .rst_b, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_b, .source_select,
    .detect_done, .vbus_above_6v, .vbus_noload_mv, .limit_setting_pin, .watchdog_expired,
    .reg_reset, .adc_done, .high_impedance_enable, .input_current_limit,
    .input_voltage_threshold, .conversion_start, .continuous_conversion(), .watchdog_restart(),
    .battery_load_enable(), .charge_enable, .minimum_system_voltage, .pulse_up_command,
    .pulse_down_command, .fast_charge_current, .precharge_current(), .termination_current(),
    .charge_voltage, .precharge_threshold_select, .recharge_offset_select()
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    $display("mismatches %0d of %0d checks", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.start;
    host_u.xfer({DEV_ADDR, 2'b01}, rx);
    chk("ack", 16'h0, 16'(rx[0]));
    host_u.xfer({a, 1'b1}, rx);
    host_u.xfer({d, 1'b1}, rx);
    host_u.stop;
  endtask
  // n bytes from index a, last one compared
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input int n = 1);
    host_u.start;
    host_u.xfer({DEV_ADDR, 2'b01}, rx);
    host_u.xfer({a, 1'b1}, rx);
    host_u.start;
    host_u.xfer({DEV_ADDR, 2'b11}, rx);
    for (int i = 1; i < n; i++)
      host_u.xfer(9'h1fe, rx);
    host_u.xfer(9'h1ff, rx);
    chk($sformatf("reg %h", a), 16'(e), 16'(rx[8:1]));
    host_u.stop;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    repeat (8) @(negedge clk);
    s = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic settle(input logic hi, input logic [13:0] mv, input logic [15:0] e);
    vbus_above_6v = hi;
    vbus_noload_mv = mv;
    repeat (8) @(negedge clk);
    chk("vth", e, 16'(input_voltage_threshold));
  endtask
  initial begin
    rst_b = 1'b0;
    {source_select, detect_done, vbus_above_6v, watchdog_expired, reg_reset, adc_done} = 6'h20;
    vbus_noload_mv = 14'd5000;
    limit_setting_pin = 6'h03;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 9; i++)
      rd(idx[i], dflt[i]);
    rd(8'h14, RD_BEYOND, 2);
    chk("limit_setting_pin", 16'h3, 16'(input_current_limit));
    chk("charge_voltage", 16'h17, 16'(charge_voltage));
    chk("chg_en", 16'h1, 16'(charge_enable));
    chk("minimum_system_voltage", 16'h5, 16'(minimum_system_voltage));
    chk("blow", 16'h1, 16'(precharge_threshold_select));
    chk("hiz", 16'h0, 16'(high_impedance_enable));
    settle(1'b0, 14'd5000, 16'd5600);
    wr(A_FAST_CHARGE_CURRENT, 8'h7f);
    rd(A_FAST_CHARGE_CURRENT, 8'h4f);
    wr(A_FAST_CHARGE_CURRENT, 8'h00);
    chk("chg_en", 16'h0, 16'(charge_enable));
    wr(A_PUMP, 8'h03);
    chk("pulse_up", 16'h0, 16'(pulse_up_command));
    wr(A_FAST_CHARGE_CURRENT, 8'h90);
    chk("pulse_up", 16'h1, 16'(pulse_up_command));
    chk("pulse_dn", 16'h1, 16'(pulse_down_command));
    wr(A_CHARGE_VOLTAGE, 8'hfe);
    rd(A_CHARGE_VOLTAGE, 8'hc2);
    wr(A_VOS, 8'hff);
    rd(A_VOS, 8'h1f);
    settle(1'b0, 14'd5000, 16'd8100);
    settle(1'b1, 14'd5000, 16'd11200);
    settle(1'b1, 14'd14000, 16'd15300);
    wr(A_VOS, 8'h00);
    settle(1'b0, 14'd1000, 16'd3900);
    wr(A_ADC, 8'h80);
    chk("conv", 16'h1, 16'(conversion_start));
    pulse(adc_done);
    chk("conv", 16'h0, 16'(conversion_start));
    wr(A_ADC, 8'h40);
    wr(A_ADC, 8'hc0);
    rd(A_ADC, 8'h40);
    wr(A_PWR, 8'h4a);
    rd(A_PWR, 8'h0a);
    chk("chg_en", 16'h0, 16'(charge_enable));
    wr(A_SRC, 8'h05);
    chk("limit_setting_pin", 16'h5, 16'(input_current_limit));
    pulse(watchdog_expired);
    rd(A_SRC, 8'h45);
    rd(A_PWR, R_PWR);
    rd(A_FAST_CHARGE_CURRENT, R_FAST_CHARGE_CURRENT);
    chk("limit_setting_pin", 16'h3, 16'(input_current_limit));
    limit_setting_pin = 6'h3f;
    pulse(detect_done);
    rd(A_SRC, 8'h48);
    source_select = 1'b0;
    pulse(detect_done);
    rd(A_SRC, 8'h7f);
    pulse(reg_reset);
    rd(A_SRC, R_SRC);
    host_u.start;
    host_u.xfer({DEV_ADDR, 2'b01}, rx);
    host_u.xfer({8'h20, 1'b1}, rx);
    chk("nack", 16'h1, 16'(rx[0]));
    host_u.stop;
    stop_test;
  end
endmodule
bind ccr_cfg_regs ccr_cfg_regs_sva chk_u (
  .clk, .rst_b, .source_select, .detect_done, .limit_setting_pin, .watchdog_expired, .adc_done,
  .input_current_limit, .input_voltage_threshold, .conversion_start, .watchdog_restart,
  .charge_enable, .fast_charge_current, .charge_voltage
);
`default_nettype wire

/* File: verification/ccr_cfg_regs_sva.sv */
// concurrent checks on the charger configuration bank ports
`timescale 1ns/10ps
`default_nettype none
module ccr_cfg_regs_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // pin events
  input wire logic        source_select,
  input wire logic        detect_done,
  input wire logic [5:0]  limit_setting_pin,
  input wire logic        watchdog_expired,
  input wire logic        adc_done,
  // outputs watched
  input wire logic [5:0]  input_current_limit,
  input wire logic [13:0] input_voltage_threshold,
  input wire logic        conversion_start,
  input wire logic        watchdog_restart,
  input wire logic        charge_enable,
  input wire logic [6:0]  fast_charge_current,
  input wire logic [5:0]  charge_voltage
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_vth_range: assert property (
    $past(rst_b, 4) |-> input_voltage_threshold >= 14'd3900 && input_voltage_threshold <= 14'd15300)
    else $error("threshold out of range");
  chk_charge_voltage_clamp: assert property (charge_voltage <= 6'h30)
    else $error("charge voltage code above clamp");
  chk_fast_charge_current_clamp: assert property (fast_charge_current <= 7'h4f)
    else $error("fast charge code above clamp");
  chk_zero_fast_charge_current: assert property (fast_charge_current == 7'h00 |-> !charge_enable)
    else $error("charging on with zero current code");
  chk_wdr_pulse: assert property (watchdog_restart |=> !watchdog_restart)
    else $error("watchdog restart did not clear");
  chk_conv_done: assert property ($rose(adc_done) |-> ##[1:6] !conversion_start)
    else $error("conversion start stuck after done");
  chk_detect_hi: assert property (
    $rose(detect_done) && source_select && limit_setting_pin >= 6'h08
    |-> ##[1:6] input_current_limit == 6'h08)
    else $error("detection did not load high source limit");
  chk_wd_defaults: assert property (
    $rose(watchdog_expired) |-> ##[1:6] fast_charge_current == 7'h20 && charge_voltage == 6'h17)
    else $error("watchdog expiry did not restore defaults");
endmodule
`default_nettype wire

/* File: verification/ccr_host_model.sv */
// i2c host master model driving the configuration bank
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half;
    repeat (8) @(negedge clk);
  endtask
  // start or repeated start, scl left low
  task automatic start;
    half;
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
  endtask
  task automatic stop;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask
  // nine bits msb first, data moves only while scl low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      half;
      sda_low = ~tx[i];
      half;
      scl = 1'b1;
      half;
      rx[i] = sda_line;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire
